/* dv/dcs_link_checker.sv */
// checker: timing relations on the five link wires between master and slave
// assumes one core clock drives both ends; instantiated beside the link
`include "dcs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dcs_link_checker (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // link wires
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe_n
);
    localparam int T_DT = `DCS_T_DT_CYC;
    logic [7:0] hi_cnt_q;
    logic [4:0] rise_cnt_q;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // cycles cs has stayed high, saturating
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hi_cnt_q <= 8'hff;
        end else if (!cs_n) begin
            hi_cnt_q <= 8'h00;
        end else if (hi_cnt_q != 8'hff) begin
            hi_cnt_q <= hi_cnt_q + 8'h01;
        end
    end
    // sclk rises within one frame
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rise_cnt_q <= 5'h00;
        end else if ($fell(cs_n)) begin
            rise_cnt_q <= 5'h00;
        end else if ($rose(sclk)) begin
            rise_cnt_q <= rise_cnt_q + 5'h01;
        end
    end
    property p_sclk_low_at_cs;
        $changed(cs_n) |-> !sclk && !$past(sclk);
    endproperty
    a_sclk_low_at_cs: assert property (p_sclk_low_at_cs)
        else $error("sclk not low at cs edge");
    property p_lead;
        $fell(cs_n) |-> !sclk [*8];
    endproperty
    a_lead: assert property (p_lead)
        else $error("sclk too soon after cs fall");
    property p_eight_clocks;
        $rose(cs_n) |-> rise_cnt_q == 5'h08;
    endproperty
    a_eight_clocks: assert property (p_eight_clocks)
        else $error("frame without eight sclk cycles");
    property p_cs_ends;
        rise_cnt_q == 5'h08 && $fell(sclk) |-> ##[1:60] $rose(cs_n);
    endproperty
    a_cs_ends: assert property (p_cs_ends)
        else $error("cs not raised after last bit");
    property p_gap;
        $fell(cs_n) |-> hi_cnt_q >= T_DT;
    endproperty
    a_gap: assert property (p_gap)
        else $error("cs high time too short");
    property p_oe_on;
        $fell(cs_n) |-> ##[1:6] !so_oe_n;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("so not driven after cs fall");
    property p_oe_off;
        cs_n [*6] |-> so_oe_n;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("so driven while cs high");
    property p_oe_hold;
        cs_n && so_oe_n |=> so_oe_n;
    endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("so enabled without cs fall");
    property p_so_steady;
        $fell(sclk) && !cs_n |=> ($stable(so) || so_oe_n) [*8];
    endproperty
    a_so_steady: assert property (p_so_steady)
        else $error("so changed away from sclk rise");
endmodule : dcs_link_checker
`default_nettype wire

/* dv/testbench.sv */
// testbench: master and slave on one link, a second slave driven by hand
// assumes both ends at default parameters and the 125 MHz core clock
`include "dcs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench import dcs_pkg::*;;
    logic core_clk_in, rst_n_in, start_in, busy_out, done_out, sleep_out, sclk_p;
    logic [7:0] tx_in, rx_out, diag_set_in, diag_out, input_reg_out, ireg2, si_cap, so_cap;
    logic [4:0] out_cfg_out, io_cfg_out, chan_out, ocfg2;
    int err_count, n_compared, cyc, i, n_done;
    logic fdone;
    localparam logic [7:0] TX2 = 8'h44;
    dcs_cmd_t cmds[3] = '{DCS_CMD_OUTCFG, DCS_CMD_IOCFG, DCS_CMD_CHAN};
    logic [4:0] dats[3] = '{5'h13, 5'h0a, 5'h15};
    logic [7:0] vals[3] = '{8'ha5, 8'h5a, 8'h81};
    dcs_link_if link();
    dcs_link_if link2();
    dcs_master dcs_master_inst (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link(link),
        .start_in(start_in), .tx_in(tx_in), .busy_out(busy_out), .rx_out(rx_out),
        .done_out(done_out));
    dcs_slave dcs_slave_inst (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link(link),
        .diag_set_in(diag_set_in), .diag_out(diag_out), .input_reg_out(input_reg_out),
        .out_cfg_out(out_cfg_out), .io_cfg_out(io_cfg_out), .chan_out(chan_out),
        .sleep_out(sleep_out), .frame_done_out(fdone));
    // second slave faces the bench instead of a master
    dcs_slave dcs_slave2_inst (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link(link2),
        .diag_set_in(8'h00), .diag_out(), .input_reg_out(ireg2), .out_cfg_out(ocfg2),
        .io_cfg_out(), .chan_out(), .sleep_out(), .frame_done_out());
    dcs_link_checker dcs_link_checker_inst (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .cs_n(link.cs_n), .sclk(link.sclk), .si(link.si), .so(link.so),
        .so_oe_n(link.so_oe_n));
    initial begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end
    // wire bits seen at each sclk fall
    always @(posedge core_clk_in) begin
        sclk_p <= link.sclk;
        if (fdone) n_done <= n_done + 1;
        if (sclk_p && !link.sclk) begin
            si_cap <= {si_cap[6:0], link.si};
            so_cap <= {so_cap[6:0], link.so};
        end
    end
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            $display("CHECK FAILED run length expected %0d seen %0d", 40000, cyc);
            results();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic results;
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    task automatic frame(input logic [7:0] tx, input logic [7:0] exp_rx, input bit look);
        int n;
        n = 0;
        tx_in <= tx;
        start_in <= 1'b1;
        @(posedge core_clk_in);
        while (busy_out !== 1'b1 && n < 50) begin
            @(posedge core_clk_in);
            n++;
        end
        start_in <= 1'b0;
        while (done_out !== 1'b1 && n < 1000) begin
            @(posedge core_clk_in);
            n++;
        end
        chk("done_out", 8'h01, {7'h00, done_out});
        chk("si wire", tx, si_cap);
        if (look) begin
            chk("rx_out", exp_rx, rx_out);
            chk("so wire", exp_rx, so_cap);
        end
        // wait out the gap so the next start is taken
        while (busy_out !== 1'b0 && n < 2000) begin
            @(posedge core_clk_in);
            n++;
        end
        chk("busy_out", 8'h00, {7'h00, busy_out});
    endtask : frame
    task automatic pulse(input logic [7:0] v);
        diag_set_in <= v;
        @(posedge core_clk_in);
        diag_set_in <= 8'h00;
        repeat (3) @(posedge core_clk_in);
    endtask : pulse
    task automatic drive2(input logic cs, input logic ck, input logic d, input int n);
        link2.cs_n <= cs;
        link2.sclk <= ck;
        link2.si <= d;
        repeat (n) @(posedge core_clk_in);
    endtask : drive2
    initial begin
        rst_n_in = 1'b0;
        start_in = 1'b0;
        tx_in = 8'h00;
        diag_set_in = 8'h00;
        link2.cs_n = 1'b1;
        link2.sclk = 1'b0;
        link2.si = 1'b0;
        repeat (3) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        @(posedge core_clk_in);
        chk("diag_out", `DCS_DIAG_RESET, diag_out);
        chk("so_oe_n", 8'h01, {7'h00, link.so_oe_n});
        frame({DCS_CMD_DIAG, 5'h00}, `DCS_DIAG_RESET, 1'b1);
        chk("diag_out", 8'h00, diag_out);
        for (i = 0; i < 3; i++) begin
            pulse(vals[i]);
            frame({cmds[i], dats[i]}, vals[i], 1'b1);
            chk("input_reg_out", {cmds[i], dats[i]}, input_reg_out);
            chk("diag_out", 8'h00, diag_out);
        end
        chk("out_cfg_out", 8'h13, {3'h0, out_cfg_out});
        chk("io_cfg_out", 8'h0a, {3'h0, io_cfg_out});
        chk("chan_out", 8'h15, {3'h0, chan_out});
        pulse(8'h3c);
        frame({DCS_CMD_NONE, 5'h1f}, 8'h3c, 1'b1);
        chk("diag_out", 8'h3c, diag_out);
        chk("input_reg_out", 8'h3f, input_reg_out);
        chk("out_cfg_out", 8'h13, {3'h0, out_cfg_out});
        repeat (`DCS_T_FAULT_CYC) @(posedge core_clk_in);
        frame({DCS_CMD_DIAG, 5'h00}, 8'h3c, 1'b1);
        frame({DCS_CMD_SLEEP, 5'h00}, 8'h00, 1'b1);
        chk("sleep_out", 8'h01, {7'h00, sleep_out});
        chk("out_cfg_out", 8'h00, {3'h0, out_cfg_out});
        frame({DCS_CMD_CHAN, 5'h1f}, 8'h00, 1'b0);
        chk("chan_out", 8'h00, {3'h0, chan_out});
        frame({DCS_CMD_WAKE, 5'h00}, 8'h00, 1'b0);
        chk("sleep_out", 8'h00, {7'h00, sleep_out});
        frame({DCS_CMD_OUTCFG, 5'h07}, 8'h00, 1'b0);
        frame({DCS_CMD_RSTREG, 5'h1f}, 8'h00, 1'b0);
        chk("out_cfg_out", 8'h00, {3'h0, out_cfg_out});
        for (i = 0; i < 8; i++) begin
            drive2(1'b1, 1'b1, 1'b1, 12);
            drive2(1'b1, 1'b0, 1'b0, 12);
        end
        chk("so_oe_n2", 8'h01, {7'h00, link2.so_oe_n});
        chk("input_reg2", 8'h00, ireg2);
        drive2(1'b0, 1'b0, 1'b0, 30);
        for (i = 7; i >= 0; i--) begin
            drive2(1'b0, 1'b1, TX2[i], 12);
            drive2(1'b0, 1'b0, TX2[i], 12);
        end
        drive2(1'b0, 1'b0, 1'b0, 30);
        chk("input_reg2", 8'h00, ireg2);
        drive2(1'b1, 1'b0, 1'b0, 20);
        chk("input_reg2", 8'h44, ireg2);
        chk("out_cfg2", 8'h04, {3'h0, ocfg2});
        chk("frame_done count", 8'h0b, n_done[7:0]);
        results();
    end
endmodule : testbench
`default_nettype wire

/* verilog/dcs_defs.svh */
// timing counts and frame layout constants for the diagnosis spi link
// assumes a 125 MHz core clock on both ends
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH
`define DCS_CLK_PERIOD_NS 8
`define DCS_FRAME_BITS 8
`define DCS_CMD_MSB 7
`define DCS_CMD_LSB 5
`define DCS_DATA_MSB 4
`define DCS_DATA_LSB 0
`define DCS_T_DT_NS 300
`define DCS_T_DT_CYC ((`DCS_T_DT_NS + `DCS_CLK_PERIOD_NS - 1) / `DCS_CLK_PERIOD_NS)
`define DCS_T_FAULT_US 200
`define DCS_T_FAULT_CYC ((`DCS_T_FAULT_US * 1000) / `DCS_CLK_PERIOD_NS)
`define DCS_T_LEAD_NS 200
`define DCS_T_LEAD_CYC ((`DCS_T_LEAD_NS + `DCS_CLK_PERIOD_NS - 1) / `DCS_CLK_PERIOD_NS)
`define DCS_SCLK_HALF 10
`define DCS_DIAG_RESET 8'hff
`endif

/* verilog/dcs_link_if.sv */
// four-wire spi link between master and slave ends
// the slave drives so directly; so_oe_n is a separate enable wire
`timescale 1ns/1ps
`default_nettype none
interface dcs_link_if;
    logic cs_n;
    logic sclk;
    logic si;
    logic so;
    logic so_oe_n;
    modport slave (input cs_n, input sclk, input si, output so, output so_oe_n);
    modport master (output cs_n, output sclk, output si, input so, input so_oe_n);
endinterface : dcs_link_if
`default_nettype wire

/* verilog/dcs_master.sv */
// master end: issues one frame of n*8 bits, sclk made by divider
// assumes so arrives asynchronously from the chain
`include "dcs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dcs_master
    import dcs_pkg::*;
#(
    parameter int CHAIN_LEN = 1,
    parameter int GAP_CYC = `DCS_T_DT_CYC
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // spi link
    dcs_link_if.master link,
    // user side
    input wire logic start_in,
    input wire logic [8*CHAIN_LEN-1:0] tx_in,
    output logic busy_out,
    output logic [8*CHAIN_LEN-1:0] rx_out,
    output logic done_out
);
    localparam int NB = 8 * CHAIN_LEN;
    initial begin
        if (CHAIN_LEN < 1 || CHAIN_LEN > 32 || GAP_CYC < 1 || GAP_CYC > 65535) begin
            $error("dcs_master: bad parameters");
        end
    end

    typedef enum logic [4:0] {
        M_IDLE = 5'h01, M_LEAD = 5'h02, M_HIGH = 5'h04, M_LOW = 5'h08, M_GAP = 5'h10
    } dcs_mst_t;

    dcs_mst_t st_q;
    logic [15:0] cnt_q;
    logic [8:0] bits_q;
    logic [NB-1:0] sh_q;
    logic cs_n_q, sclk_q, si_q, done_q, busy_q;
    logic so_m, so_s;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            so_m <= 1'b0;
            so_s <= 1'b0;
        end else begin
            so_m <= link.so;
            so_s <= so_m;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= M_IDLE;
            cnt_q <= 16'h0000;
            bits_q <= 9'h000;
            sh_q <= '0;
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            si_q <= 1'b0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (st_q)
                M_IDLE: if (start_in) begin
                    sh_q <= tx_in;
                    si_q <= tx_in[NB-1]; // RL11
                    cs_n_q <= 1'b0; // RL1 RL10
                    cnt_q <= 16'(`DCS_T_LEAD_CYC);
                    bits_q <= 9'(NB); // RL15 RL16
                    st_q <= M_LEAD;
                    busy_q <= 1'b1;
                end
                M_LEAD, M_LOW: if (cnt_q != 16'h0000) begin
                    cnt_q <= cnt_q - 16'h0001;
                end else if (bits_q == 9'h000) begin
                    cs_n_q <= 1'b1; // RL4 RL10
                    done_q <= 1'b1;
                    cnt_q <= 16'(GAP_CYC);
                    st_q <= M_GAP;
                end else begin
                    sclk_q <= 1'b1;
                    si_q <= sh_q[NB-1];
                    cnt_q <= 16'(`DCS_SCLK_HALF);
                    st_q <= M_HIGH;
                end
                M_HIGH: if (cnt_q != 16'h0000) begin
                    cnt_q <= cnt_q - 16'h0001;
                end else begin
                    sclk_q <= 1'b0;
                    sh_q <= {sh_q[NB-2:0], so_s};
                    bits_q <= bits_q - 9'h001;
                    cnt_q <= 16'(`DCS_SCLK_HALF);
                    st_q <= M_LOW;
                end
                M_GAP: if (cnt_q != 16'h0000) begin
                    cnt_q <= cnt_q - 16'h0001; // RL18
                end else begin
                    st_q <= M_IDLE;
                    busy_q <= 1'b0;
                end
                default: begin
                    st_q <= M_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    assign link.cs_n = cs_n_q;
    assign link.sclk = sclk_q;
    assign link.si = si_q;
    assign busy_out = busy_q;
    assign rx_out = sh_q;
    assign done_out = done_q;
endmodule : dcs_master
`default_nettype wire

/* verilog/dcs_pkg.sv */
// types shared by both ends of the diagnosis spi link
package dcs_pkg;
    typedef enum logic [2:0] {
        DCS_CMD_DIAG = 3'h0,
        DCS_CMD_NONE = 3'h1,
        DCS_CMD_OUTCFG = 3'h2,
        DCS_CMD_IOCFG = 3'h3,
        DCS_CMD_RSTREG = 3'h4,
        DCS_CMD_SLEEP = 3'h5,
        DCS_CMD_WAKE = 3'h6,
        DCS_CMD_CHAN = 3'h7
    } dcs_cmd_t;
endpackage : dcs_pkg

/* verilog/dcs_slave.sv */
// slave end: 8-bit diagnosis spi shift register with command latch
// assumes cs_n, sclk, si come asynchronously from the master pins
//
// Functional notes
// RL1: cs falling edge starts a transfer
// RL2: sample si on sclk falling edge
// RL3: update so on sclk rising edge
// RL4: master ends every frame raising cs
// RL5: cs high ignores sclk, si; so tristate
// RL6: cs fall loads diagnosis into shifter
// RL7: cs rise copies shifter to input register
// RL8: cs rise clears diagnosis flags
// RL9: only valid commands execute at frame end
// RL10: master keeps sclk low around cs edges
// RL11: si data most significant bit first
// RL12: eight-bit frame, command and data parts
// RL13: so data msb first after rise
// RL14: one shifter, far end feeds so chain
// RL15: single device gets exactly eight clocks
// RL16: chain of n gets n times eight
// RL17: reset or sleep restores register defaults
// RL18: cs high at least 300 ns
// RL19: longer cs high for fault settle
// RL20: bits 7:5 command, 4:0 data
// RL21: invalid command keeps diagnosis uncleared
// RL22: synchronise pins, detect edges internally
`include "dcs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dcs_slave
    import dcs_pkg::*;
#(
    parameter int FRAME_BITS = `DCS_FRAME_BITS
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // spi link
    dcs_link_if.slave link,
    // device side
    input wire logic [7:0] diag_set_in,
    output logic [7:0] diag_out,
    output logic [7:0] input_reg_out,
    output logic [4:0] out_cfg_out,
    output logic [4:0] io_cfg_out,
    output logic [4:0] chan_out,
    output logic sleep_out,
    output logic frame_done_out
);
    initial begin
        if (FRAME_BITS != 8) $error("dcs_slave: frame must be 8 bits");
    end

    logic cs_lvl, cs_rise, cs_fall;
    logic sclk_rise, sclk_fall;
    logic si_lvl;
    logic [7:0] shift_q;
    logic so_q, so_oe_n_q;
    logic active_q;
    logic [7:0] diag_q;
    logic [7:0] input_reg_q;
    logic [4:0] out_cfg_q, io_cfg_q, chan_q;
    logic sleep_q;
    logic done_q;
    dcs_cmd_t cmd;

    // cs idles high, sclk and si idle low
    dcs_sync #(
        .RST_VAL(1'b1)
    ) u_cs (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .async_in(link.cs_n),
        .level_out(cs_lvl),
        .rise_out(cs_rise),
        .fall_out(cs_fall)
    ); // RL22
    dcs_sync #(
        .RST_VAL(1'b0)
    ) u_sclk (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .async_in(link.sclk),
        .level_out(),
        .rise_out(sclk_rise),
        .fall_out(sclk_fall)
    ); // RL22
    dcs_sync #(
        .RST_VAL(1'b0)
    ) u_si (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .async_in(link.si),
        .level_out(si_lvl),
        .rise_out(),
        .fall_out()
    ); // RL22

    function automatic logic cmd_valid(input dcs_cmd_t c, input logic asleep);
        if (asleep) return c == DCS_CMD_WAKE;
        return c != DCS_CMD_NONE;
    endfunction : cmd_valid

    assign cmd = dcs_cmd_t'(shift_q[`DCS_CMD_MSB:`DCS_CMD_LSB]); // RL20

    // transfer window, opened only by cs falling
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            active_q <= 1'b0;
        end else if (cs_fall) begin
            active_q <= 1'b1; // RL1
        end else if (cs_rise || cs_lvl) begin
            active_q <= 1'b0; // RL4
        end
    end

    // shifter: load on cs fall, shift in on sclk fall
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_q <= 8'h00;
        end else if (cs_fall) begin
            shift_q <= diag_q; // RL6
        end else if (active_q && !cs_lvl && sclk_fall) begin
            shift_q <= {shift_q[6:0], si_lvl}; // RL2 RL11 RL14
        end
    end

    // so driver: msb out, updated on sclk rise, tristate when cs high
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            so_q <= 1'b0;
            so_oe_n_q <= 1'b1;
        end else if (cs_fall) begin
            so_q <= diag_q[7]; // RL13
            so_oe_n_q <= 1'b0;
        end else if (cs_lvl) begin
            so_oe_n_q <= 1'b1; // RL5
        end else if (active_q && sclk_rise) begin
            so_q <= shift_q[7]; // RL3 RL13 RL14
        end
    end

    assign link.so = so_q;
    assign link.so_oe_n = so_oe_n_q;

    // input register latched on cs rise
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            input_reg_q <= 8'h00;
            done_q <= 1'b0;
        end else begin
            done_q <= cs_rise && active_q;
            if (cs_rise && active_q) begin
                input_reg_q <= shift_q; // RL7 RL12
            end
        end
    end

    // command execution, sleep and register reset
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            out_cfg_q <= 5'h00;
            io_cfg_q <= 5'h00;
            chan_q <= 5'h00;
            sleep_q <= 1'b0;
        end else if (cs_rise && active_q && cmd_valid(cmd, sleep_q)) begin // RL9
            unique case (cmd)
                DCS_CMD_OUTCFG: out_cfg_q <= shift_q[`DCS_DATA_MSB:`DCS_DATA_LSB];
                DCS_CMD_IOCFG: io_cfg_q <= shift_q[`DCS_DATA_MSB:`DCS_DATA_LSB];
                DCS_CMD_CHAN: chan_q <= shift_q[`DCS_DATA_MSB:`DCS_DATA_LSB];
                DCS_CMD_RSTREG, DCS_CMD_SLEEP: begin
                    out_cfg_q <= 5'h00; // RL17
                    io_cfg_q <= 5'h00;
                    chan_q <= 5'h00;
                    sleep_q <= (cmd == DCS_CMD_SLEEP);
                end
                DCS_CMD_WAKE: sleep_q <= 1'b0;
                DCS_CMD_DIAG, DCS_CMD_NONE: begin
                end
            endcase
        end
    end

    // diagnosis flags: sticky, cleared at frame end by a valid command other than RSTREG or SLEEP, which reload DCS_DIAG_RESET
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            diag_q <= `DCS_DIAG_RESET;
        end else if (cs_rise && active_q && cmd_valid(cmd, sleep_q)) begin
            if (cmd == DCS_CMD_SLEEP || cmd == DCS_CMD_RSTREG) begin
                diag_q <= `DCS_DIAG_RESET | diag_set_in; // RL17
            end else begin
                diag_q <= diag_set_in; // RL8 set wins
            end
        end else begin
            diag_q <= diag_q | diag_set_in; // RL21
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            diag_out <= `DCS_DIAG_RESET;
            input_reg_out <= 8'h00;
            out_cfg_out <= 5'h00;
            io_cfg_out <= 5'h00;
            chan_out <= 5'h00;
            sleep_out <= 1'b0;
            frame_done_out <= 1'b0;
        end else begin
            diag_out <= diag_q;
            input_reg_out <= input_reg_q;
            out_cfg_out <= out_cfg_q;
            io_cfg_out <= io_cfg_q;
            chan_out <= chan_q;
            sleep_out <= sleep_q;
            frame_done_out <= done_q;
        end
    end
endmodule : dcs_slave
`default_nettype wire

/* verilog/dcs_sync.sv */
// two-flop synchroniser with edge flags read from the second stage and a third delay flop
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module dcs_sync #(
    // idle level of the pin, so no false edge follows reset
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // async in, sync out
    input wire logic async_in,
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
            prev_q <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_out = sync_q;
    assign rise_out = sync_q & ~prev_q;
    assign fall_out = ~sync_q & prev_q;
endmodule : dcs_sync
`default_nettype wire
